// *** logic/wtb_wakeup_timer.sv ***
// Wake-up countdown timer with APB registers and card detection sequencing
`default_nettype none
module wtb_wakeup_timer
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wtb_pkg::ADDR_W-1:0] paddr,
   input wire logic [wtb_pkg::DATA_W-1:0] pwdata,
   output logic [wtb_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Oscillator and second timer
   input wire logic lfo_tick,
   input wire logic [wtb_pkg::CNT_W-1:0] second_count,
   input wire logic second_timer_underflow,
   input wire logic card_present,
   // System requests
   output logic wake_request,
   output logic trim_start,
   output logic second_timer_start,
   output logic rf_field_on,
   output logic power_down_request,
   output logic wake_timer_irq_flag,
   output logic card_found_flag
);
   // -----------------------------------------------------------
   // Register state
   // -----------------------------------------------------------
   wtb_pkg::wtb_ctrl_s ctrl;
   wtb_pkg::wtb_cd_e cd_state;
   logic wake_timer_active;
   logic [7:0] wake_reload_high;
   logic [7:0] wake_reload_low;
   logic [wtb_pkg::CNT_W-1:0] count;
   logic [wtb_pkg::PRE_W-1:0] pre;

   // -----------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------
   wire logic setup = psel & ~penable;
   wire logic wr = psel & penable & pready & pwrite;
   wire logic [5:0] idx = paddr[wtb_pkg::ADDR_W-1:2];
   wire logic aligned = paddr[1:0] == 2'h0;
   wire logic hit_sec_hi = aligned && idx == wtb_pkg::IDX_SEC_HI;
   wire logic hit_sec_lo = aligned && idx == wtb_pkg::IDX_SEC_LO;
   wire logic hit_ctrl = aligned && idx == wtb_pkg::IDX_CTRL;
   wire logic hit_rel_hi = aligned && idx == wtb_pkg::IDX_REL_HI;
   wire logic hit_rel_lo = aligned && idx == wtb_pkg::IDX_REL_LO;
   wire logic hit_cnt_hi = aligned && idx == wtb_pkg::IDX_CNT_HI;
   wire logic hit_cnt_lo = aligned && idx == wtb_pkg::IDX_CNT_LO;
   wire logic hit_status = aligned && idx == wtb_pkg::IDX_STATUS;
   wire logic mapped = hit_sec_hi | hit_sec_lo | hit_ctrl | hit_rel_hi | hit_rel_lo
      | hit_cnt_hi | hit_cnt_lo | hit_status;
   wire logic wr_ctrl = wr & hit_ctrl;
   wire logic permit = pwdata[wtb_pkg::BIT_PERMIT];
   wire logic start_ev = wr_ctrl & permit & pwdata[wtb_pkg::BIT_RUN];
   wire logic stop_ev = wr_ctrl & permit & ~pwdata[wtb_pkg::BIT_RUN];
   wire logic [wtb_pkg::CNT_W-1:0] wake_reload_value = {wake_reload_high, wake_reload_low};
   wire logic [7:0] ctrl_rd = {wake_timer_active, 1'b0, ctrl};
   wire logic [7:0] status_rd = {6'h00, card_found_flag, wake_timer_irq_flag};

   logic [7:0] rd_byte;
   always_comb
   begin
      if (hit_sec_hi)
         rd_byte = second_count[15:8];
      else if (hit_sec_lo)
         rd_byte = second_count[7:0];
      else if (hit_ctrl)
         rd_byte = ctrl_rd;
      else if (hit_rel_hi)
         rd_byte = wake_reload_high;
      else if (hit_rel_lo)
         rd_byte = wake_reload_low;
      else if (hit_cnt_hi)
         rd_byte = count[15:8];
      else if (hit_cnt_lo)
         rd_byte = count[7:0];
      else if (hit_status)
         rd_byte = status_rd;
      else
         rd_byte = 8'h00;
   end

   // -----------------------------------------------------------
   // Prescaler and countdown
   // -----------------------------------------------------------
   wire logic [wtb_pkg::PRE_W-1:0] pre_mask =
      (ctrl.wake_clock_select == wtb_pkg::SEL_DIV1) ? wtb_pkg::PRE_DIV1 :
      (ctrl.wake_clock_select == wtb_pkg::SEL_DIV8) ? wtb_pkg::PRE_DIV8 :
      (ctrl.wake_clock_select == wtb_pkg::SEL_DIV16) ? wtb_pkg::PRE_DIV16 :
      wtb_pkg::PRE_DIV32;
   wire logic tick = lfo_tick & ((pre & pre_mask) == pre_mask);
   wire logic underflow = wake_timer_active & tick & ~start_ev
      & (count <= wtb_pkg::CNT_ONE);
   wire logic restart = ctrl.wake_auto_reload | ctrl.auto_card_detect;
   wire logic cd_go = underflow & ctrl.auto_card_detect & (cd_state == wtb_pkg::WTB_CD_IDLE);
   wire logic cd_end = (cd_state == wtb_pkg::WTB_CD_FIELD) & second_timer_underflow;
   wire logic wr_status = wr & hit_status;

   logic [wtb_pkg::CNT_W-1:0] next_count;
   logic next_active;
   always_comb
   begin
      next_count = count;
      next_active = wake_timer_active;
      if (start_ev)
      begin
         next_count = wake_reload_value;
         next_active = 1'b1;
      end
      else if (stop_ev)
         next_active = 1'b0;
      else if (underflow)
      begin
         next_count = restart ? wake_reload_value : '0;
         next_active = restart;
      end
      else if (wake_timer_active & tick)
         next_count = count - wtb_pkg::CNT_ONE;
   end

   // -----------------------------------------------------------
   // Registers
   // -----------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= setup ? {24'h000000, rd_byte} : '0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= wtb_pkg::CTRL_RESET;
         wake_reload_high <= 8'h00;
         wake_reload_low <= 8'h00;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= pwdata[5:0];
         if (wr & hit_rel_hi)
            wake_reload_high <= pwdata[7:0];
         if (wr & hit_rel_lo)
            wake_reload_low <= pwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= '0;
         wake_timer_active <= 1'b0;
         pre <= '0;
      end
      else
      begin
         count <= next_count;
         wake_timer_active <= next_active;
         pre <= start_ev ? '0 : pre + {4'h0, lfo_tick};
      end
   end

   // -----------------------------------------------------------
   // Underflow actions and card detection
   // -----------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cd_state <= wtb_pkg::WTB_CD_IDLE;
         wake_request <= 1'b0;
         trim_start <= 1'b0;
         second_timer_start <= 1'b0;
         rf_field_on <= 1'b0;
         power_down_request <= 1'b0;
         wake_timer_irq_flag <= 1'b0;
         card_found_flag <= 1'b0;
      end
      else
      begin
         wake_request <= underflow & (ctrl.auto_wake_on_underflow | ctrl.auto_card_detect);
         trim_start <= underflow & ctrl.auto_osc_trim;
         second_timer_start <= cd_go;
         power_down_request <= cd_end & ~card_present & ctrl.auto_wake_on_underflow;
         wake_timer_irq_flag <= underflow
            | (wake_timer_irq_flag & ~(wr_status & pwdata[wtb_pkg::BIT_WAKE_FLAG]));
         card_found_flag <= (cd_end & card_present)
            | (card_found_flag & ~(wr_status & pwdata[wtb_pkg::BIT_CARD_FLAG]));
         case (cd_state)
            wtb_pkg::WTB_CD_IDLE:
               if (cd_go)
               begin
                  cd_state <= wtb_pkg::WTB_CD_FIELD;
                  rf_field_on <= 1'b1;
               end
            wtb_pkg::WTB_CD_FIELD:
               if (second_timer_underflow)
               begin
                  cd_state <= wtb_pkg::WTB_CD_IDLE;
                  rf_field_on <= 1'b0;
               end
            default:
               cd_state <= wtb_pkg::WTB_CD_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   localparam logic [wtb_pkg::CNT_W-1:0] CNT1 = wtb_pkg::CNT_ONE;
   sequence rd_setup(logic h);
      setup & ~pwrite & h;
   endsequence
   sequence field_phase;
      rf_field_on & ~second_timer_underflow;
   endsequence
   sequence uf_when(logic en);
      underflow & en;
   endsequence

   sec_lo_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rd_setup(hit_sec_lo) |=> prdata[7:0] == $past(second_count[7:0]))
      else $error("second low byte read wrong");
   sec_hi_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rd_setup(hit_sec_hi) |=> prdata[7:0] == $past(second_count[15:8]))
      else $error("second high byte read wrong");
   cnt_hi_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rd_setup(hit_cnt_hi) |=> prdata == {24'h000000, $past(count[15:8])})
      else $error("wake high byte read wrong");
   cnt_lo_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rd_setup(hit_cnt_lo) |=> prdata == {24'h000000, $past(count[7:0])})
      else $error("wake low byte read wrong");
   permit_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr_ctrl & ~permit & ~underflow |=> $stable(wake_timer_active))
      else $error("running changed without permit");
   start_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      start_ev |=> wake_timer_active && count == $past(wake_reload_value))
      else $error("start did not load reload value");
   trim_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      underflow & ctrl.auto_osc_trim |=> trim_start)
      else $error("trim not launched");
   irq_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      underflow |=> wake_timer_irq_flag)
      else $error("irq flag not set");
   stop_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      underflow & ~restart |=> ~wake_timer_active && count == '0)
      else $error("timer did not stop at zero");
   no_gap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      underflow & restart |=> wake_timer_active && count == $past(wake_reload_value))
      else $error("restart left a gap");
   field_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cd_go |=> field_phase or (rf_field_on & second_timer_underflow ##1 ~rf_field_on))
      else $error("field not switched on");
   card_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cd_end & card_present |=> card_found_flag ##0 ~power_down_request)
      else $error("card not reported");
   dec_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wake_timer_active & tick & ~underflow & ~wr_ctrl |=> count == $past(count) - CNT1)
      else $error("count did not decrement");
   bit6_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rd_setup(hit_ctrl) |=> ~prdata[wtb_pkg::BIT_PERMIT])
      else $error("bit 6 read nonzero");
   wake_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      uf_when(ctrl.auto_wake_on_underflow) |=> wake_request)
      else $error("wake not requested");
   card_wake_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      uf_when(ctrl.auto_card_detect) |=> wake_request)
      else $error("detection did not wake system");
   no_card_down_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cd_end & ~card_present & ctrl.auto_wake_on_underflow |=> power_down_request ##0 ~rf_field_on)
      else $error("power down not requested");
   stop_run_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      stop_ev |=> ~wake_timer_active)
      else $error("stop did not halt timer");
   div1_tick_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ctrl.wake_clock_select == wtb_pkg::SEL_DIV1) & lfo_tick |-> tick)
      else $error("undivided clock did not tick");
   pre_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wake_timer_active & lfo_tick & ~tick & ~start_ev |=> $stable(count))
      else $error("count moved between prescaled ticks");
   reload_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr & (hit_rel_hi | hit_rel_lo) & ~tick |=> $stable(count))
      else $error("reload write changed count");
endmodule
`default_nettype wire

// *** logic/wtb_pkg.sv ***
// Constants, types and register map of the wake-up timer block
// Function
// - Low byte of the second timer live count is readable, read-only.
// - High byte of the second timer live count is readable, read-only.
// - With bit 2 or bit 4 set, timer expiry wakes the system; bit 4 also starts card detection.
// - Control bit 7 shows running; writes change it only with permit set.
// - Control bit 6 is write-only; one permits the running bit update.
// - With bit 5 set, each underflow launches an oscillator trim.
// - With bit 4 set, underflow runs card detection; card sets the card found flag.
// - At the underflow that starts each card detection the countdown restarts with no gap.
// - The second timer period sets the RF field-on probe time.
// - Bit 3 set reloads after zero; with bits 3 and 4 cleared it counts to zero and stops.
// - Every underflow sets the wake timer interrupt flag.
// - With bit 2 set, each underflow wakes the system.
// - Bits 1 to 0 select the oscillator undivided, or by 8, 16, 32.
// - Reload value enters the counter at a start event or at an underflow that restarts.
// - High byte of the wake timer live count is readable, read-only.
// - Low byte of the wake timer live count is readable, read-only.
`default_nettype none
package wtb_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 16;
   localparam int PRE_W = 5;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_SEC_HI = 6'h21;
   localparam logic [5:0] IDX_SEC_LO = 6'h22;
   localparam logic [5:0] IDX_CTRL = 6'h23;
   localparam logic [5:0] IDX_REL_HI = 6'h24;
   localparam logic [5:0] IDX_REL_LO = 6'h25;
   localparam logic [5:0] IDX_CNT_HI = 6'h26;
   localparam logic [5:0] IDX_CNT_LO = 6'h27;
   localparam logic [5:0] IDX_STATUS = 6'h30;
   // Control and status bit positions
   localparam int BIT_RUN = 7;
   localparam int BIT_PERMIT = 6;
   localparam int BIT_WAKE_FLAG = 0;
   localparam int BIT_CARD_FLAG = 1;
   // Prescaler terminal masks per clock select code
   localparam logic [PRE_W-1:0] PRE_DIV1 = 5'h00;
   localparam logic [PRE_W-1:0] PRE_DIV8 = 5'h07;
   localparam logic [PRE_W-1:0] PRE_DIV16 = 5'h0F;
   localparam logic [PRE_W-1:0] PRE_DIV32 = 5'h1F;
   localparam logic [1:0] SEL_DIV1 = 2'h0;
   localparam logic [1:0] SEL_DIV8 = 2'h1;
   localparam logic [1:0] SEL_DIV16 = 2'h2;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   typedef struct packed {
      logic auto_osc_trim;
      logic auto_card_detect;
      logic wake_auto_reload;
      logic auto_wake_on_underflow;
      logic [1:0] wake_clock_select;
   } wtb_ctrl_s;
   typedef enum logic {WTB_CD_IDLE, WTB_CD_FIELD} wtb_cd_e;
endpackage
`default_nettype wire

// *** logic/wtb_dummy_none.sv ***
// Intentionally empty compile unit
`default_nettype none
`default_nettype wire

// *** bench/tb_wakeup_timer_block.sv ***
// Self-checking testbench of the wake-up timer block
`default_nettype none
module tb_wakeup_timer_block;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // Signals
   // ------------------------------
   logic ref_clk, reset_n, psel, penable, pwrite, lfo_tick, stu, card_present;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, wake_request, trim_start, second_timer_start, rf_field_on;
   logic power_down_request, wake_timer_irq_flag, card_found_flag;
   logic [15:0] second_count;
   int errors, n_tests;
   wtb_wakeup_timer i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lfo_tick(lfo_tick), .second_count(second_count),
      .second_timer_underflow(stu), .card_present(card_present),
      .wake_request(wake_request), .trim_start(trim_start),
      .second_timer_start(second_timer_start), .rf_field_on(rf_field_on),
      .power_down_request(power_down_request), .wake_timer_irq_flag(wake_timer_irq_flag),
      .card_found_flag(card_found_flag));
   // ------------------------------
   // Bus and stimulus tasks
   // ------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int guard;
      guard = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         guard++;
      end
      while (pready !== 1'b1 && guard < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (guard >= 50) chk("pready wait", 1, 0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, {24'h000000, d}, rd, err);
   endtask
   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h00000000, rd, err);
      chk(name, exp, rd);
   endtask
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         lfo_tick <= 1'b1;
         @(posedge ref_clk);
         lfo_tick <= 1'b0;
      end
      #1;
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs();
      logic [31:0] rd;
      logic err;
      rdc("control after reset", 8'h8C, 32'h00);
      wr(8'h98, 8'hFF);
      rdc("count high read only", 8'h98, 32'h00);
      apb(1'b0, 8'h00, 32'h0, rd, err);
      chk("unmapped error", 1, err);
      rdc("second count high", 8'h84, 32'hA5);
      rdc("second count low", 8'h88, 32'hC3);
   endtask
   task automatic t_permit();
      wr(8'h90, 8'h00);
      wr(8'h94, 8'h03);
      wr(8'h8C, 8'h88);
      rdc("start without permit", 8'h8C, 32'h08);
      wr(8'h8C, 8'hC8);
      rdc("start with permit", 8'h8C, 32'h88);
      rdc("loaded count", 8'h9C, 32'h03);
      wr(8'h94, 8'h05);
      rdc("reload not before start", 8'h9C, 32'h03);
      wr(8'h94, 8'h03);
      tick(2);
      rdc("decrement per tick", 8'h9C, 32'h01);
      tick(1);
      chk("underflow flag", 1, wake_timer_irq_flag);
      chk("no wake without enable", 0, wake_request);
      rdc("auto reload count", 8'h9C, 32'h03);
      rdc("still running", 8'h8C, 32'h88);
      rdc("status flag", 8'hC0, 32'h01);
      wr(8'hC0, 8'h01);
      #1;
      chk("flag cleared", 0, wake_timer_irq_flag);
   endtask
   task automatic t_oneshot();
      wr(8'h8C, 8'hE4);
      tick(3);
      chk("trim pulse", 1, trim_start);
      chk("wake pulse", 1, wake_request);
      chk("one shot flag", 1, wake_timer_irq_flag);
      rdc("stopped at zero", 8'h8C, 32'h24);
      rdc("count zero", 8'h9C, 32'h00);
      wr(8'hC0, 8'h01);
   endtask
   task automatic t_div();
      for (int sel = 1; sel <= 3; sel++)
      begin
         wr(8'h8C, 8'hC8 | 8'(sel));
         tick((4 << sel) - 1);
         rdc("prescaled hold", 8'h9C, 32'h03);
         tick(1);
         rdc("prescaled step", 8'h9C, 32'h02);
      end
      wr(8'h8C, 8'h40);
   endtask
   task automatic t_card(input logic c);
      wr(8'h94, 8'h01);
      wr(8'h8C, 8'hD4);
      tick(1);
      chk("wake on expiry", 1, wake_request);
      chk("second timer start", 1, second_timer_start);
      @(posedge ref_clk);
      #1;
      chk("field on", 1, rf_field_on);
      rdc("restart no gap", 8'h9C, 32'h01);
      chk("field held", 1, rf_field_on);
      @(posedge ref_clk);
      stu <= 1'b1;
      card_present <= c;
      @(posedge ref_clk);
      stu <= 1'b0;
      #1;
      chk("field off", 0, rf_field_on);
      chk("power down", !c, power_down_request);
      chk("card flag", c, card_found_flag);
      wr(8'h8C, 8'h40);
      wr(8'hC0, 8'h03);
   endtask
   // ------------------------------
   // Clock, reset, sequence, watchdog
   // ------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      reset_n = 1'b0;
      {psel, penable, pwrite, lfo_tick, stu, card_present} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      second_count = 16'hA5C3;
      errors = 0;
      n_tests = 0;
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_regs();
      t_permit();
      t_oneshot();
      t_div();
      t_card(1'b0);
      t_card(1'b1);
      end_sim();
   end
   initial
   begin
      #(20000 * 50);
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire
